/* File: verilog/irq_route_and_clock_restart.sv */
`timescale 1ns/1ps
module irq_route_and_clock_restart (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // gpio pins carrying the routed inputs
  input wire logic gpio_port1_bit3,
  input wire logic gpio_port1_bit4,
  // internal sources
  input wire logic internal_irq_change,
  input wire logic internal_dma_request,
  // serial irq frame position from the frame engine
  input wire logic frame_active,
  input wire logic [7:0] frame_clock_count,
  input wire logic frame_done,
  // clock-run line, open drain
  input wire logic clock_run_line_in,
  output logic clock_run_line_out,
  output logic clock_run_line_oe,
  // serial interrupt line, two signals
  output logic serial_interrupt_line_out,
  output logic serial_interrupt_line_oe,
  // wake, smi and interrupt
  output logic wake_event,
  output logic smi_event,
  output logic irq
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic routed_irq_input_a;
  logic routed_irq_input_b;
  logic run_sampled;
  logic [1:0] last_routed;

  always_comb begin
    next_sync1 = {clock_run_line_in, gpio_port1_bit4, gpio_port1_bit3};
    next_sync2 = sync1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign routed_irq_input_a = sync2[0];
  assign routed_irq_input_b = sync2[1];
  assign run_sampled = sync2[2];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] irq_route_a_select;
  logic [7:0] irq_route_b_select;
  logic [7:0] gpio_ctl;
  logic [2:0] status;
  logic [2:0] mask;
  logic [7:0] next_a_select;
  logic [7:0] next_b_select;
  logic [7:0] next_gpio_ctl;
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [2:0] events;
  logic clock_restart_enable;
  logic wr_go;
  logic rd_go;

  assign clock_restart_enable = irq_route_a_select[irq_route_pkg::enable_bit];
  // a write lands on the edge where the master sees waitrequest low
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;

  always_comb begin
    next_a_select = irq_route_a_select;
    next_b_select = irq_route_b_select;
    next_gpio_ctl = gpio_ctl;
    next_mask = mask;
    next_readdata = avs_readdata;
    // one wait state: waitrequest drops for one cycle per access
    next_waitrequest = !(avs_read || avs_write) || !avs_waitrequest;
    next_status = status;
    if (wr_go) begin
      case (avs_address)
        irq_route_pkg::addr_select_a: next_a_select = avs_writedata[7:0];
        irq_route_pkg::addr_select_b: next_b_select = avs_writedata[7:0];
        irq_route_pkg::addr_gpio_ctl: next_gpio_ctl = avs_writedata[7:0];
        irq_route_pkg::addr_status: next_status = status & ~avs_writedata[2:0];
        irq_route_pkg::addr_mask: next_mask = avs_writedata[2:0];
        default: ;
      endcase
    end
    next_status = next_status | events; // set wins over clear
    if (rd_go) begin
      case (avs_address)
        irq_route_pkg::addr_select_a: next_readdata = {24'h0, irq_route_a_select};
        irq_route_pkg::addr_select_b: next_readdata = {24'h0, irq_route_b_select};
        irq_route_pkg::addr_gpio_ctl: next_readdata = {24'h0, gpio_ctl};
        irq_route_pkg::addr_status: next_readdata = {29'h0, status};
        irq_route_pkg::addr_mask: next_readdata = {29'h0, mask};
        irq_route_pkg::addr_pins: next_readdata = {29'h0, run_sampled, last_routed};
        default: next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_route_a_select <= irq_route_pkg::select_reset;
      irq_route_b_select <= irq_route_pkg::select_reset;
      gpio_ctl <= irq_route_pkg::gpio_ctl_reset;
      status <= irq_route_pkg::status_reset;
      mask <= irq_route_pkg::status_reset;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      irq_route_a_select <= next_a_select;
      irq_route_b_select <= next_b_select;
      gpio_ctl <= next_gpio_ctl;
      status <= next_status;
      mask <= next_mask;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // ----------------------------------------
  // edge detect, wake and smi
  // ----------------------------------------
  logic [1:0] pol_edge;
  logic next_wake;
  logic next_smi;
  logic next_irq;
  logic restart_done;

  always_comb begin
    // polarity 0 picks rising, 1 picks falling
    pol_edge[0] = gpio_ctl[irq_route_pkg::pol_a_bit] ?
      (last_routed[0] && !routed_irq_input_a) : (!last_routed[0] && routed_irq_input_a);
    pol_edge[1] = gpio_ctl[irq_route_pkg::pol_b_bit] ?
      (last_routed[1] && !routed_irq_input_b) : (!last_routed[1] && routed_irq_input_b);
    events = {restart_done, pol_edge};
    next_wake = |(pol_edge & gpio_ctl[irq_route_pkg::wake_en_bit +: 2]);
    next_smi = |(pol_edge & gpio_ctl[irq_route_pkg::smi_en_bit +: 2]);
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      last_routed <= 2'h3;
      wake_event <= 1'b0;
      smi_event <= 1'b0;
      irq <= 1'b0;
    end else begin
      last_routed <= {routed_irq_input_b, routed_irq_input_a};
      wake_event <= next_wake;
      smi_event <= next_smi;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // serial irq slot driver
  // ----------------------------------------
  function automatic logic [7:0] sample_clock(input logic [3:0] slot);
    // slot n rides in frame n+1, sampled at 3*(n+1)-1
    sample_clock = 8'({4'h0, slot} * irq_route_pkg::frame_clocks
      + irq_route_pkg::frame_clocks - irq_route_pkg::sample_offset);
  endfunction

  logic slot_hit_a;
  logic slot_hit_b;
  logic drove_low;
  logic next_drove_low;
  logic next_sirq_out;
  logic next_sirq_oe;
  logic sirq_allowed;

  always_comb begin
    slot_hit_a = (irq_route_a_select[3:0] != 4'h0) && !routed_irq_input_a
      && (frame_clock_count == sample_clock(irq_route_a_select[3:0]));
    slot_hit_b = (irq_route_b_select[3:0] != 4'h0) && !routed_irq_input_b
      && (frame_clock_count == sample_clock(irq_route_b_select[3:0]));
    // clock-run must be low (clock running) before the line is driven
    sirq_allowed = clock_restart_enable && !run_sampled;
    next_sirq_out = 1'b1;
    next_sirq_oe = 1'b0;
    next_drove_low = 1'b0;
    if (frame_active && sirq_allowed && (slot_hit_a || slot_hit_b)) begin
      next_sirq_out = 1'b0;
      next_sirq_oe = 1'b1;
      next_drove_low = 1'b1;
    end else if (drove_low) begin
      next_sirq_out = 1'b1;
      next_sirq_oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drove_low <= 1'b0;
      serial_interrupt_line_out <= 1'b1;
      serial_interrupt_line_oe <= 1'b0;
    end else begin
      drove_low <= next_drove_low;
      serial_interrupt_line_out <= next_sirq_out;
      serial_interrupt_line_oe <= next_sirq_oe;
    end
  end

  // ----------------------------------------
  // clock-run restart request
  // ----------------------------------------
  // the trigger is taken on sys_clk here; with the bus clock stopped the
  // frame engine cannot see it anyway, so a clocked latch loses nothing
  irq_route_pkg::run_state_t run_state;
  irq_route_pkg::run_state_t next_run_state;
  logic [1:0] high_count;
  logic [1:0] next_high_count;
  logic [1:0] hold_count;
  logic [1:0] next_hold_count;
  logic dma_last;
  logic trigger;
  logic next_run_out_low;

  always_comb begin
    trigger = internal_irq_change || (internal_dma_request && !dma_last)
      || (|pol_edge);
    next_run_state = run_state;
    next_hold_count = hold_count;
    next_high_count = run_sampled ?
      ((high_count == irq_route_pkg::high_samples) ? high_count : 2'(high_count + 2'h1))
      : 2'h0;
    next_run_out_low = 1'b0;
    restart_done = 1'b0;
    case (run_state)
      irq_route_pkg::run_idle: begin
        if (trigger) begin
          next_run_state = irq_route_pkg::run_wait_high;
        end
      end
      irq_route_pkg::run_wait_high: begin
        if (frame_done) begin
          next_run_state = irq_route_pkg::run_idle;
          restart_done = 1'b1;
        end else if (run_sampled && high_count == irq_route_pkg::high_samples) begin
          // line high twice: clock stopping, pull it low
          next_run_state = irq_route_pkg::run_drive;
          next_hold_count = 2'h0;
          next_run_out_low = 1'b1;
        end
      end
      irq_route_pkg::run_drive: begin
        next_run_out_low = 1'b1;
        next_hold_count = 2'(hold_count + 2'h1);
        if (2'(hold_count + 2'h1) == irq_route_pkg::hold_edges) begin
          next_run_out_low = 1'b0;
          next_run_state = irq_route_pkg::run_pending;
        end
      end
      irq_route_pkg::run_pending: begin
        if (frame_done) begin
          next_run_state = irq_route_pkg::run_idle;
          restart_done = 1'b1;
        end else if (run_sampled) begin
          next_run_state = irq_route_pkg::run_wait_high;
        end
      end
      default: next_run_state = irq_route_pkg::run_idle;
    endcase
    if (!clock_restart_enable) begin
      next_run_state = irq_route_pkg::run_idle;
      next_run_out_low = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_state <= irq_route_pkg::run_idle;
      high_count <= 2'h0;
      hold_count <= 2'h0;
      dma_last <= 1'b0;
      clock_run_line_oe <= 1'b0;
      clock_run_line_out <= 1'b0;
    end else begin
      run_state <= next_run_state;
      high_count <= next_high_count;
      hold_count <= next_hold_count;
      dma_last <= internal_dma_request;
      clock_run_line_oe <= next_run_out_low;
      clock_run_line_out <= 1'b0;
    end
  end

endmodule

/* File: verilog/irq_route_pkg.sv */
//
// Contract
// - two 4-bit slot fields, zero disables input
// - input a from port1 bit3, b bit4
// - inputs raise wake and smi, edge by polarity
// - restart enable off kills serial irq, clock-run
// - clock-run sampled, only pulled low or released
// - pull clock-run low before driving serial irq
// - dma request while stopped pulls clock-run low
// - high clock-run means stopped, low running
// - irq edge or dma while high pulls low
// - hold low two rising edges then release
// - never assert while line already held low
// - assert only after two high samples
// - trigger is any irq edge or dma assertion; code takes only the polarity-selected edge of inputs a and b
// - keep requesting until delivered in a cycle
// - slot is three clocks: sample, recovery, release
package irq_route_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] addr_select_a = 4'h0;
  localparam logic [3:0] addr_select_b = 4'h1;
  localparam logic [3:0] addr_gpio_ctl = 4'h2;
  localparam logic [3:0] addr_status = 4'h3;
  localparam logic [3:0] addr_mask = 4'h4;
  localparam logic [3:0] addr_pins = 4'h5;

  localparam int enable_bit = 7;
  localparam logic [7:0] select_reset = 8'h00;
  localparam logic [7:0] gpio_ctl_reset = 8'h00;

  // gpio_ctl: [0] polarity a, [1] polarity b, [2] wake en a, [3] wake en b,
  // [4] smi en a, [5] smi en b
  localparam int pol_a_bit = 0;
  localparam int pol_b_bit = 1;
  localparam int wake_en_bit = 2;
  localparam int smi_en_bit = 4;

  // status: [0] edge a, [1] edge b, [2] clock restart done
  localparam int status_width = 3;
  localparam logic [2:0] status_reset = 3'h0;

  // ----------------------------------------
  // serial irq frame timing
  // ----------------------------------------
  localparam logic [7:0] frame_clocks = 8'h03;
  localparam logic [7:0] sample_offset = 8'h01;
  localparam logic [7:0] max_frame_count = 8'h60;
  localparam logic [1:0] hold_edges = 2'h2;
  localparam logic [1:0] high_samples = 2'h2;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } od_pin_t;

  typedef enum logic [1:0] {
    run_idle = 2'b00,
    run_wait_high = 2'b01,
    run_drive = 2'b11,
    run_pending = 2'b10
  } run_state_t;

endpackage

/* File: bench/irq_route_monitor.sv */
`timescale 1ns/1ps
module irq_route_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register writes
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // lines
  input wire logic [7:0] frame_clock_count,
  input wire logic clock_run_line_in,
  input wire logic clock_run_line_out,
  input wire logic clock_run_line_oe,
  input wire logic serial_interrupt_line_out,
  input wire logic serial_interrupt_line_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] sa, sb;
  logic en;
  logic [1:0] hi;
  // ----------------------------------------
  // shadow of select fields, high-run counter
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {en, sa, sb} <= '0;
      hi <= 2'h0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == irq_route_pkg::addr_select_a) begin
        {en, sa} <= {avs_writedata[irq_route_pkg::enable_bit], avs_writedata[3:0]};
      end
      if (avs_write && !avs_waitrequest && avs_address == irq_route_pkg::addr_select_b) begin
        sb <= avs_writedata[3:0];
      end
      hi <= !clock_run_line_in ? 2'h0 : (hi == 2'h3 ? hi : hi + 2'h1);
    end
  end
  property p_od; clock_run_line_oe |-> !clock_run_line_out; endproperty
  a_od: assert property (p_od) else $error("clock-run driven high");
  property p_hold;
    $rose(clock_run_line_oe) |-> clock_run_line_oe[*2] ##1 !clock_run_line_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("clock-run pull not two cycles");
  property p_pre; $rose(clock_run_line_oe) |-> $past(hi) >= 2'h2; endproperty
  a_pre: assert property (p_pre) else $error("clock-run pulled without high");
  property p_off; $rose(clock_run_line_oe) |-> en; endproperty
  a_off: assert property (p_off) else $error("clock-run pulled while disabled");
  property p_shape;
    $rose(serial_interrupt_line_oe) |-> !serial_interrupt_line_out
      ##1 (serial_interrupt_line_oe && serial_interrupt_line_out) ##1 !serial_interrupt_line_oe;
  endproperty
  a_shape: assert property (p_shape) else $error("bad slot drive shape");
  property p_slot;
    $rose(serial_interrupt_line_oe) |-> (sa != 4'h0 && $past(frame_clock_count) == 3 * sa + 2)
      || (sb != 4'h0 && $past(frame_clock_count) == 3 * sb + 2);
  endproperty
  a_slot: assert property (p_slot) else $error("drive outside selected slot");
  property p_sen; serial_interrupt_line_oe |-> en && !clock_run_line_in; endproperty
  a_sen: assert property (p_sen) else $error("serial drive while off or stopped");
  property p_rst;
    disable iff (1'b0) !rst_n |=> !clock_run_line_oe && !serial_interrupt_line_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("drivers on after reset");
  c_run: cover property ($rose(clock_run_line_oe));
  c_sirq: cover property ($rose(serial_interrupt_line_oe));
  c_cfg: cover property (en && sb != 4'h0);
endmodule

bind irq_route_and_clock_restart irq_route_monitor i_irq_route_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .frame_clock_count(frame_clock_count), .clock_run_line_in(clock_run_line_in),
  .clock_run_line_out(clock_run_line_out), .clock_run_line_oe(clock_run_line_oe),
  .serial_interrupt_line_out(serial_interrupt_line_out),
  .serial_interrupt_line_oe(serial_interrupt_line_oe));

/* File: bench/clk_gen_model.sv */
`timescale 1ns/1ps
module clk_gen_model (
  // clock
  input wire logic sys_clk,
  // device pull and bench requests
  input wire logic dev_oe,
  input wire logic stop,
  input wire logic start,
  // resolved line
  output logic line
);
  logic gen_low = 1'b1;
  // a pull while stopped restarts the clock; the generator then holds the line
  always @(posedge sys_clk) begin
    if (stop) begin
      gen_low <= 1'b0;
    end else if (start || dev_oe) begin
      gen_low <= 1'b1;
    end
  end
  // pull-up: nobody drives high
  assign line = !(gen_low || dev_oe);
endmodule

/* File: bench/tb_irq_route_and_clock_restart.sv */
`timescale 1ns/1ps
module tb_irq_route_and_clock_restart;
  logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, pin_a = 1'b1, pin_b = 1'b1, chg = 1'b0, dma = 1'b0;
  logic f_act = 1'b0, f_done = 1'b0, stop = 1'b0, start = 1'b0, sir_q = 1'b0;
  logic [7:0] f_cnt = 8'h00;
  logic run_in, run_out, run_oe, sir_out, sir_oe, wake, smi, irq;
  logic [7:0] hits[$];
  int err_total = 0, checks = 0, oe_cyc = 0, wk = 0, sm = 0;
  irq_route_and_clock_restart i_irq_route_and_clock_restart (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gpio_port1_bit3(pin_a), .gpio_port1_bit4(pin_b),
    .internal_irq_change(chg), .internal_dma_request(dma), .frame_active(f_act),
    .frame_clock_count(f_cnt), .frame_done(f_done), .clock_run_line_in(run_in),
    .clock_run_line_out(run_out), .clock_run_line_oe(run_oe),
    .serial_interrupt_line_out(sir_out), .serial_interrupt_line_oe(sir_oe),
    .wake_event(wake), .smi_event(smi), .irq(irq));
  clk_gen_model i_clk_gen_model (.sys_clk(sys_clk), .dev_oe(run_oe), .stop(stop),
    .start(start), .line(run_in));
  initial forever #10 sys_clk = ~sys_clk;
  // sample settled outputs half a cycle after the edge
  always @(negedge sys_clk) begin
    if (run_oe === 1'b1) oe_cyc++;
    if (wake === 1'b1) wk++;
    if (smi === 1'b1) sm++;
    if (sir_oe === 1'b1 && !sir_q) hits.push_back(f_cnt - 8'h01);
    sir_q = (sir_oe === 1'b1);
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) err_total++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // let one edge pass so a following call never re-raises in this step
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic gen(input logic s);
    if (s) stop <= 1'b1;
    else start <= 1'b1;
    @(posedge sys_clk);
    stop <= 1'b0;
    start <= 1'b0;
    idle(6);
  endtask
  task automatic frame(input int n_exp);
    hits = {};
    f_act <= 1'b1;
    for (int i = 0; i < 52; i++) begin
      f_cnt <= i[7:0];
      @(posedge sys_clk);
    end
    f_act <= 1'b0;
    f_done <= 1'b1;
    @(posedge sys_clk);
    f_done <= 1'b0;
    idle(2);
    chk(hits.size(), n_exp);
  endtask
  task automatic kick;
    chg <= 1'b1;
    @(posedge sys_clk);
    chg <= 1'b0;
    idle(30);
  endtask
  task automatic stop_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    idle(6);
    rst_n <= 1'b1;
    idle(1);
    rd(4'h0, 32'hff, 32'h0);
    rd(4'h3, 32'h7, 32'h0);
    wr(4'h9, 32'hff);
    rd(4'h9, 32'hffffffff, 32'h0);
    pin_a <= 1'b0;
    idle(4);
    rd(4'h5, 32'h3, 32'h2);
    gen(1'b1);
    kick();
    chk(oe_cyc, 0);
    gen(1'b0);
    // slots 3 and 5 stay clear of the internal sources
    wr(4'h0, 32'h83);
    wr(4'h1, 32'h85);
    kick();
    chk(oe_cyc, 0);
    frame(1);
    chk(hits[0], 8'd11);
    gen(1'b1);
    kick();
    chk(oe_cyc, 2);
    gen(1'b1);
    idle(30);
    chk(oe_cyc, 4);
    frame(1);
    rd(4'h3, 32'h4, 32'h4);
    wr(4'h4, 32'h4);
    chk(irq, 1'b1);
    wr(4'h4, 32'h0);
    chk(irq, 1'b0);
    wr(4'h4, 32'h4);
    wr(4'h3, 32'h4);
    chk(irq, 1'b0);
    gen(1'b1);
    dma <= 1'b1;
    idle(30);
    chk(oe_cyc, 6);
    frame(1);
    dma <= 1'b0;
    pin_b <= 1'b0;
    idle(4);
    frame(2);
    chk(hits[0], 8'd11);
    chk(hits[1], 8'd17);
    wr(4'h1, 32'h80);
    frame(1);
    // clock stopped and nothing changed: no pull, so no slot drive either
    gen(1'b1);
    frame(0);
    chk(oe_cyc, 6);
    gen(1'b0);
    wr(4'h0, 32'h03);
    frame(0);
    wr(4'h2, 32'h3c);
    pin_a <= 1'b1;
    idle(8);
    chk(wk, 1);
    chk(sm, 1);
    wr(4'h2, 32'h3d);
    pin_a <= 1'b0;
    idle(8);
    chk(wk, 2);
    pin_a <= 1'b1;
    idle(8);
    chk(wk, 2);
    rd(4'h3, 32'h3, 32'h1);
    stop_test();
  end
  // run needs about 700 cycles; allow well over ten times that
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule
